// ---- bench/slrc_top_tb.sv ----
// self-checking bench for the sleep and retention regulator control block
`timescale 1ns/1ns
module slrc_top_tb;
	import slrc_pkg::*;
	logic        sys_clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        startup_done;
	logic        sleep_instr;
	logic        wake_req;
	logic        trim_cmp_high;
	logic        power_chain_en;
	logic        retention_on;
	logic [15:0] retention_trim;
	logic        retention_tco;
	logic        retention_short;
	logic        sleep_active;
	logic [2:0]  sleep_mode;
	logic [7:0]  gates;
	logic [31:0] rd;
	logic        err;
	int          fail_count;
	int          num_checks;
	int          cyc;
	logic [31:0] t_a;

	slrc_top slrc_top_inst (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.pready           (pready),
		.prdata           (prdata),
		.pslverr          (pslverr),
		.startup_done     (startup_done),
		.sleep_instr      (sleep_instr),
		.wake_req         (wake_req),
		.trim_cmp_high    (trim_cmp_high),
		.power_chain_en   (power_chain_en),
		.retention_on     (retention_on),
		.retention_trim   (retention_trim),
		.retention_tco    (retention_tco),
		.retention_short  (retention_short),
		.sleep_active     (sleep_active),
		.sleep_mode       (sleep_mode),
		.gate_two_wire    (gates[7]),
		.gate_timer_two   (gates[6]),
		.gate_timer_zero  (gates[5]),
		.amp_low_current  (gates[4]),
		.gate_timer_one   (gates[3]),
		.gate_spi_block   (gates[2]),
		.gate_serial_zero (gates[1]),
		.gate_converter   (gates[0])
	);

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50)
			check("pready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		// outputs launched at this edge are read only after it settles
		#1;
	endtask

	task automatic pulse(input logic to_wake);
		@(posedge sys_clk);
		if (to_wake)
			wake_req <= 1'b1;
		else
			sleep_instr <= 1'b1;
		@(posedge sys_clk);
		wake_req <= 1'b0;
		sleep_instr <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	// polls the active flag; returns cycles from t_a until it dropped
	task automatic wait_sync();
		int n;
		n = 0;
		cyc = 0;
		do begin
			apb(1'b0, RET_CTRL_ADDR, 32'h0);
			n++;
		end while (rd[CTL_ACTIVE_BIT] !== 1'b0 && n < 400);
		cyc = int'($time - t_a) / SYS_CLK_PERIOD_NS;
		check("sync done", {31'h0, rd[CTL_ACTIVE_BIT]}, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask

	initial begin
		#4000000;
		fail_count++;
		stop_test();
	end

	initial begin
		fail_count = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, sleep_instr, wake_req, trim_cmp_high, startup_done} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		// reset values and unmapped slot
		apb(1'b0, SLEEP_CTRL_ADDR, 32'h0); check("sleep_ctrl rst", rd, 32'h00);
		check("mapped err", {31'h0, err}, 32'h0);
		apb(1'b0, POWER_GATE0_ADDR, 32'h0); check("gate0 rst", rd, 32'h00);
		apb(1'b0, RET_CTRL_ADDR, 32'h0); check("ctrl rst", rd, 32'h01);
		check("chain rst", {31'h0, power_chain_en}, 32'h1);
		apb(1'b1, 12'hffc, 32'hff);
		check("unmapped err", {31'h0, err}, 32'h1);
		apb(1'b0, 12'hffc, 32'h0); check("unmapped data", rd, 32'h0);
		apb(1'b1, SLEEP_CTRL_ADDR, 32'hff);
		apb(1'b0, SLEEP_CTRL_ADDR, 32'h0); check("sleep_ctrl mask", rd, 32'h0f);
		check("sleep_mode", {29'h0, sleep_mode}, 32'h7);
		apb(1'b1, SLEEP_CTRL_ADDR, 32'h00);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, POWER_GATE0_ADDR, 32'h1 << i);
			check("gate out", {24'h0, gates}, 32'h1 << i);
		end
		apb(1'b0, POWER_GATE0_ADDR, 32'h0); check("gate rd", rd, 32'h80);
		apb(1'b1, POWER_GATE0_ADDR, 32'h00);
		// writes refused while calibration is enabled
		apb(1'b1, RET_TRIM_HIGH_ADDR, 32'h0f);
		apb(1'b1, RET_TRIM_LOW_ADDR, 32'h06);
		apb(1'b1, RET_CTRL_ADDR, 32'h15);
		apb(1'b0, RET_CTRL_ADDR, 32'h0); check("ctrl locked", rd & 32'h17, 32'h01);
		apb(1'b0, RET_TRIM_LOW_ADDR, 32'h0); check("low locked", rd, 32'h0);
		// disable, active flag until the third regulator tick
		apb(1'b1, RET_CTRL_ADDR, 32'h00);
		t_a = $time;
		apb(1'b0, RET_CTRL_ADDR, 32'h0); check("active set", rd & 32'h08, 32'h08);
		wait_sync();
		check("sync delay", {31'h0, cyc >= 2 * TICK_CYCLES}, 32'h1);
		// ordered load for low supply
		apb(1'b1, RET_TRIM_HIGH_ADDR, 32'h0f);
		apb(1'b1, RET_TRIM_LOW_ADDR, 32'h06);
		t_a = $time;
		wait_sync();
		check("trim applied", {16'h0, retention_trim}, 32'h0f06);
		apb(1'b1, RET_TRIM_HIGH_ADDR, 32'h20);
		apb(1'b1, RET_CTRL_ADDR, 32'h14);
		t_a = $time;
		wait_sync();
		apb(1'b0, RET_TRIM_HIGH_ADDR, 32'h0); check("lone high", rd, 32'h0f);
		check("trim kept", {16'h0, retention_trim}, 32'h0f06);
		check("tco short", {30'h0, retention_tco, retention_short}, 32'h3);
		// unarmed sleep ignored, then every select armed
		apb(1'b1, SLEEP_CTRL_ADDR, 32'h04);
		pulse(1'b0);
		check("unarmed", {31'h0, sleep_active}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, SLEEP_CTRL_ADDR, 32'(i * 2 + 1));
			pulse(1'b0);
			check("armed sleep", {31'h0, sleep_active}, 32'h1);
			check("sel out", {29'h0, sleep_mode}, 32'(i));
			check("chain", {31'h0, power_chain_en}, 32'((i == 2 || i == 3) ? 0 : 1));
			check("ret on", {31'h0, retention_on}, 32'((i == 2 || i == 3) ? 1 : 0));
			pulse(1'b1);
			check("woken", {30'h0, sleep_active, power_chain_en}, 32'h1);
		end
		// second reset: automatic calibration
		startup_done <= 1'b1;
		trim_cmp_high <= 1'b1;
		do_reset();
		apb(1'b1, SLEEP_CTRL_ADDR, 32'h05);
		pulse(1'b0);
		t_a = $time;
		check("chain held", {31'h0, power_chain_en}, 32'h1);
		cyc = 0;
		while (power_chain_en !== 1'b0 && cyc < 6000) begin
			@(posedge sys_clk);
			cyc++;
		end
		check("first cycle len", {31'h0, cyc >= 14 * 312}, 32'h1);
		check("chain off", {31'h0, power_chain_en}, 32'h0);
		check("trim moved", {31'h0, retention_trim != 16'h0}, 32'h1);
		pulse(1'b1);
		apb(1'b0, RET_CTRL_ADDR, 32'h0); check("done cleared", rd & 32'h03, 32'h01);
		apb(1'b1, SLEEP_CTRL_ADDR, 32'h00);
		trim_cmp_high <= 1'b0;
		apb(1'b0, RET_TRIM_LOW_ADDR, 32'h0);
		t_a = rd;
		repeat (4 * 312) @(posedge sys_clk);
		apb(1'b0, RET_TRIM_LOW_ADDR, 32'h0); check("recal", {31'h0, rd < t_a}, 32'h1);
		// disable mid-run: values settle within five ticks
		apb(1'b1, RET_CTRL_ADDR, 32'h00);
		repeat (5 * 312 + 4) @(posedge sys_clk);
		apb(1'b0, RET_TRIM_LOW_ADDR, 32'h0);
		t_a = rd;
		apb(1'b0, RET_CTRL_ADDR, 32'h0); check("ctrl stable", rd & 32'h09, 32'h0);
		repeat (3 * 312) @(posedge sys_clk);
		apb(1'b0, RET_TRIM_LOW_ADDR, 32'h0); check("low stable", rd, t_a);
		stop_test();
	end
endmodule

// ---- hdl/slrc_top.sv ----
// sleep select, peripheral power gates and retention regulator calibration
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module slrc_top
	import slrc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        startup_done,
	input  wire logic        sleep_instr,
	input  wire logic        wake_req,
	input  wire logic        trim_cmp_high,
	output logic             power_chain_en,
	output logic             retention_on,
	output logic [15:0]      retention_trim,
	output logic             retention_tco,
	output logic             retention_short,
	output logic             sleep_active,
	output logic [2:0]       sleep_mode,
	output logic             gate_two_wire,
	output logic             gate_timer_two,
	output logic             gate_timer_zero,
	output logic             amp_low_current,
	output logic             gate_timer_one,
	output logic             gate_spi_block,
	output logic             gate_serial_zero,
	output logic             gate_converter
);

	function automatic logic is_deep(input logic [2:0] sel);
		is_deep = (sel == SLRC_SEL_PWR_DOWN) || (sel == SLRC_SEL_PWR_SAVE);
	endfunction

	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic [7:0]  sleep_ctrl_r;
	logic [7:0]  power_gate_reg0_r;
	logic        en_sw_r;
	logic        tco_r;
	logic        short_r;
	logic        done_r;
	logic [7:0]  trim_low_r;
	logic [7:0]  trim_high_r;
	logic [7:0]  high_hold_r;
	logic        high_pend_r;
	logic [1:0]  sync_cnt_r;
	logic        en_app_r;
	logic [15:0] trim_app_r;
	logic        tco_app_r;
	logic        short_app_r;
	logic        trim_valid_r;
	logic [8:0]  tick_cnt_r;
	logic        tick;
	logic [4:0]  cal_cnt_r;
	slrc_state_t state_r;
	slrc_state_t state_nxt;

	logic        acc;
	logic        wr;
	logic        rd_hit;
	logic        wr_ctrl;
	logic        wr_low;
	logic        wr_high;
	logic        cal_run;
	logic        cal_step;
	logic        cal_finish;
	logic        woke;
	logic [15:0] trim_cur;
	logic [7:0]  ctrl_rd;
	logic [31:0] rd_val;

	// answer one cycle into the access phase
	assign acc     = psel && penable && !pready_r;
	assign wr      = psel && penable && pready_r && pwrite && !pslverr_r;
	assign wr_ctrl = wr && (paddr == RET_CTRL_ADDR);
	assign wr_low  = wr && (paddr == RET_TRIM_LOW_ADDR) && !en_sw_r;
	assign wr_high = wr && (paddr == RET_TRIM_HIGH_ADDR) && !en_sw_r;
	assign trim_cur = {trim_high_r, trim_low_r};

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[CTL_EN_BIT]     = en_sw_r;
		ctrl_rd[CTL_DONE_BIT]   = done_r;
		ctrl_rd[CTL_TCO_BIT]    = tco_r;
		ctrl_rd[CTL_ACTIVE_BIT] = (sync_cnt_r != 2'h0) || (en_app_r != en_sw_r);
		ctrl_rd[CTL_SHORT_BIT]  = short_r;
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr == SLEEP_CTRL_ADDR) begin
			rd_val = {24'h00_0000, sleep_ctrl_r & SLEEP_CTRL_MASK};
		end else if (paddr == POWER_GATE0_ADDR) begin
			rd_val = {24'h00_0000, power_gate_reg0_r};
		end else if (paddr == RET_CTRL_ADDR) begin
			rd_val = {24'h00_0000, ctrl_rd};
		end else if (paddr == RET_TRIM_LOW_ADDR) begin
			rd_val = {24'h00_0000, trim_low_r};
		end else if (paddr == RET_TRIM_HIGH_ADDR) begin
			rd_val = {24'h00_0000, trim_high_r};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc;
			pslverr_r <= acc && !rd_hit;
			if (acc) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_ctrl_r <= SLEEP_CTRL_RST;
		end else if (wr && paddr == SLEEP_CTRL_ADDR) begin
			sleep_ctrl_r <= pwdata[7:0] & SLEEP_CTRL_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_gate_reg0_r <= POWER_GATE0_RST;
		end else if (wr && paddr == POWER_GATE0_ADDR) begin
			power_gate_reg0_r <= pwdata[7:0];
		end
	end

	// clock stop requests, bit 4 the amplifier low current select; the gated blocks keep their state while stopped
	assign gate_two_wire    = power_gate_reg0_r[PG_TWI_BIT];
	assign gate_timer_two   = power_gate_reg0_r[PG_TIM2_BIT];
	assign gate_timer_zero  = power_gate_reg0_r[PG_TIM0_BIT];
	assign amp_low_current  = power_gate_reg0_r[PG_AMP_BIT];
	assign gate_timer_one   = power_gate_reg0_r[PG_TIM1_BIT];
	assign gate_spi_block   = power_gate_reg0_r[PG_SPI_BIT];
	assign gate_serial_zero = power_gate_reg0_r[PG_SER0_BIT];
	assign gate_converter   = power_gate_reg0_r[PG_CONV_BIT];

	// regulator clock rate as a tick; the analog side runs at this pace
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 9'h000;
		end else if (tick_cnt_r == TICK_LAST) begin
			tick_cnt_r <= 9'h000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 9'h001;
		end
	end
	assign tick = (tick_cnt_r == TICK_LAST);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_sw_r <= 1'b1;
			tco_r   <= 1'b0;
			short_r <= 1'b0;
		end else if (wr_ctrl) begin
			en_sw_r <= pwdata[CTL_EN_BIT];
			if (!en_sw_r) begin
				tco_r   <= pwdata[CTL_TCO_BIT];
				short_r <= pwdata[CTL_SHORT_BIT];
			end
		end
	end

	// a high write only parks; the low write commits both unless a control write dropped the parked high or a calibration step takes that cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_hold_r <= TRIM_HIGH_RST;
			high_pend_r <= 1'b0;
		end else if (wr_high) begin
			high_hold_r <= pwdata[7:0];
			high_pend_r <= 1'b1;
		end else if (wr_low || wr_ctrl) begin
			high_pend_r <= 1'b0;
		end
	end

	assign cal_run    = en_app_r && startup_done &&
	                    (state_r == SLRC_ST_ACTIVE || state_r == SLRC_ST_WAIT);
	assign cal_step   = cal_run && tick;
	assign cal_finish = cal_step && (cal_cnt_r == CAL_TICKS_LAST);
	assign woke       = (state_r == SLRC_ST_DEEP || state_r == SLRC_ST_LIGHT) && wake_req;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_low_r  <= TRIM_LOW_RST;
			trim_high_r <= TRIM_HIGH_RST;
		end else if (cal_step) begin
			// comparator high means retention output above main: raise trim to lower it
			if (trim_cmp_high && trim_cur != 16'hffff) begin
				{trim_high_r, trim_low_r} <= trim_cur + 16'h0001;
			end else if (!trim_cmp_high && trim_cur != 16'h0000) begin
				{trim_high_r, trim_low_r} <= trim_cur - 16'h0001;
			end
		end else if (wr_low) begin
			trim_low_r <= pwdata[7:0];
			if (high_pend_r) begin
				trim_high_r <= high_hold_r;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_cnt_r <= 5'h00;
		end else if (!cal_run || cal_finish) begin
			cal_cnt_r <= 5'h00;
		end else if (cal_step) begin
			cal_cnt_r <= cal_cnt_r + 5'h01;
		end
	end

	// set wins over the clear taken at wake
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r <= 1'b0;
		end else if (cal_finish) begin
			done_r <= 1'b1;
		end else if (woke) begin
			done_r <= 1'b0;
		end
	end

	// valid trim exists after a cycle or an ordered software load
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_valid_r <= 1'b0;
		end else if (cal_finish || wr_low) begin
			trim_valid_r <= 1'b1;
		end
	end

	// applied on the third tick, so never before two full regulator periods
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_cnt_r <= 2'h0;
		end else if (wr_ctrl || wr_low) begin
			sync_cnt_r <= SYNC_TICKS;
		end else if (tick && sync_cnt_r != 2'h0) begin
			sync_cnt_r <= sync_cnt_r - 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_app_r    <= 1'b1;
			trim_app_r  <= {TRIM_HIGH_RST, TRIM_LOW_RST};
			tco_app_r   <= 1'b0;
			short_app_r <= 1'b0;
		end else if (tick && sync_cnt_r == 2'h1 && !(wr_ctrl || wr_low)) begin
			en_app_r    <= en_sw_r;
			trim_app_r  <= trim_cur;
			tco_app_r   <= tco_r;
			short_app_r <= short_r;
		end else if (cal_step) begin
			trim_app_r  <= trim_cur;
		end
	end

	// sleep sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SLRC_ST_ACTIVE: begin
				if (sleep_instr && sleep_ctrl_r[SLP_ARM_BIT]) begin
					if (is_deep(sleep_ctrl_r[SLP_SEL_LSB +: 3])) begin
						state_nxt = trim_valid_r ? SLRC_ST_DEEP : SLRC_ST_WAIT;
					end else begin
						state_nxt = SLRC_ST_LIGHT;
					end
				end
			end
			SLRC_ST_WAIT: begin
				if (wake_req) begin
					state_nxt = SLRC_ST_ACTIVE;
				end else if (trim_valid_r) begin
					state_nxt = SLRC_ST_DEEP;
				end
			end
			SLRC_ST_DEEP: begin
				if (wake_req) begin
					state_nxt = SLRC_ST_ACTIVE;
				end
			end
			SLRC_ST_LIGHT: begin
				if (wake_req) begin
					state_nxt = SLRC_ST_ACTIVE;
				end
			end
			default: begin
				state_nxt = SLRC_ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SLRC_ST_ACTIVE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign power_chain_en  = (state_r != SLRC_ST_DEEP);
	assign retention_on    = (state_r == SLRC_ST_DEEP);
	assign retention_trim  = trim_app_r;
	assign retention_tco   = tco_app_r;
	assign retention_short = short_app_r;
	assign sleep_active    = (state_r != SLRC_ST_ACTIVE);
	assign sleep_mode      = sleep_ctrl_r[SLP_SEL_LSB +: 3];

	AST_CHAIN_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		power_chain_en == 1'b0 |-> trim_valid_r) else $error("power chain off without valid trim");
	AST_RET_SUPPLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_r == SLRC_ST_DEEP) |-> retention_on && !power_chain_en) else $error("retention not on in deep");
	AST_TRIM_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_r == SLRC_ST_DEEP) && !wr_low |=> $stable(trim_app_r)) else $error("trim moved in deep sleep");
	AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cal_finish |=> done_r) else $error("done flag not set");
	AST_WRITE_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr && paddr == RET_TRIM_LOW_ADDR && en_sw_r && !cal_step |=> $stable(trim_low_r))
		else $error("trim written while enabled");
	AST_UNARMED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == SLRC_ST_ACTIVE && sleep_instr && !sleep_ctrl_r[SLP_ARM_BIT] |=> state_r == SLRC_ST_ACTIVE)
		else $error("slept while unarmed");
	AST_TRIM_UP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cal_step && trim_cmp_high && trim_cur != 16'hffff |=> trim_cur == $past(trim_cur) + 16'h0001)
		else $error("trim not raised on high output");
	AST_APPLY_LATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_ctrl |=> $stable(en_app_r) [*1] ##1 (sync_cnt_r != 2'h0)) else $error("write applied too early");
	AST_ACTIVE_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sync_cnt_r != 2'h0 |-> ctrl_rd[CTL_ACTIVE_BIT]) else $error("active flag low during sync");
	AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sleep_ctrl_r[7:4] == 4'h0) else $error("reserved sleep bits set");
	AST_GATE_TWI: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr && paddr == POWER_GATE0_ADDR |=> gate_two_wire == $past(pwdata[PG_TWI_BIT]))
		else $error("two wire gate not following write");
	AST_LONE_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_high && !cal_step |=> $stable(trim_high_r)) else $error("high trim taken without low write");

endmodule

// ---- inc/slrc_pkg.sv ----
// constants for the sleep and retention regulator control block
package slrc_pkg;
	localparam int          SYS_CLK_PERIOD_NS = 50;
	localparam int          REG_CLK_PERIOD_NS = 15625;
	localparam int          TICK_CYCLES       = REG_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
	localparam logic [8:0]  TICK_LAST         = 9'(TICK_CYCLES - 1);
	localparam logic [1:0]  SYNC_TICKS        = 2'h3;
	localparam logic [4:0]  CAL_TICKS_LAST    = 5'h0f;

	localparam logic [7:0]  SLEEP_CTRL_IDX    = 8'h53;
	localparam logic [7:0]  POWER_GATE0_IDX   = 8'h64;
	localparam logic [7:0]  RET_CTRL_IDX      = 8'h70;
	localparam logic [7:0]  RET_TRIM_LOW_IDX  = 8'h71;
	localparam logic [7:0]  RET_TRIM_HIGH_IDX = 8'h72;
	localparam logic [11:0] SLEEP_CTRL_ADDR   = {2'h0, SLEEP_CTRL_IDX, 2'h0};
	localparam logic [11:0] POWER_GATE0_ADDR  = {2'h0, POWER_GATE0_IDX, 2'h0};
	localparam logic [11:0] RET_CTRL_ADDR     = {2'h0, RET_CTRL_IDX, 2'h0};
	localparam logic [11:0] RET_TRIM_LOW_ADDR = {2'h0, RET_TRIM_LOW_IDX, 2'h0};
	localparam logic [11:0] RET_TRIM_HIGH_ADDR = {2'h0, RET_TRIM_HIGH_IDX, 2'h0};

	localparam logic [7:0]  SLEEP_CTRL_RST    = 8'h00;
	localparam logic [7:0]  POWER_GATE0_RST   = 8'h00;
	localparam logic [7:0]  TRIM_LOW_RST      = 8'h00;
	localparam logic [7:0]  TRIM_HIGH_RST     = 8'h00;
	localparam logic [7:0]  SLEEP_CTRL_MASK   = 8'h0f;

	localparam int          SLP_ARM_BIT       = 0;
	localparam int          SLP_SEL_LSB       = 1;
	localparam int          CTL_EN_BIT        = 0;
	localparam int          CTL_DONE_BIT      = 1;
	localparam int          CTL_TCO_BIT       = 2;
	localparam int          CTL_ACTIVE_BIT    = 3;
	localparam int          CTL_SHORT_BIT     = 4;
	localparam int          PG_CONV_BIT       = 0;
	localparam int          PG_SER0_BIT       = 1;
	localparam int          PG_SPI_BIT        = 2;
	localparam int          PG_TIM1_BIT       = 3;
	localparam int          PG_AMP_BIT        = 4;
	localparam int          PG_TIM0_BIT       = 5;
	localparam int          PG_TIM2_BIT       = 6;
	localparam int          PG_TWI_BIT        = 7;

	typedef enum logic [2:0] {
		SLRC_SEL_IDLE      = 3'h0,
		SLRC_SEL_ADC_NR    = 3'h1,
		SLRC_SEL_PWR_DOWN  = 3'h2,
		SLRC_SEL_PWR_SAVE  = 3'h3,
		SLRC_SEL_RSVD4     = 3'h4,
		SLRC_SEL_RSVD5     = 3'h5,
		SLRC_SEL_STANDBY   = 3'h6,
		SLRC_SEL_EXT_STBY  = 3'h7
	} slrc_sel_t;

	typedef enum logic [1:0] {
		SLRC_ST_ACTIVE = 2'h0,
		SLRC_ST_WAIT   = 2'h1,
		SLRC_ST_DEEP   = 2'h3,
		SLRC_ST_LIGHT  = 2'h2
	} slrc_state_t;
endpackage
